// [shared/dma_mode_consts.vh]
`ifndef DMA_MODE_CONSTS_VH
`define DMA_MODE_CONSTS_VH
// register byte offsets: channel control 0..3, then mode register
`define OFS_CTRL0 8'h00
`define OFS_CTRL1 8'h04
`define OFS_CTRL2 8'h08
`define OFS_CTRL3 8'h0c
`define OFS_MODE 8'h10
`define OFS_STATUS 8'h14
`define CTRL_RESET 32'h00000000
// field positions
`define B_DEST_WAIT 24
`define B_RSV_HI 23
`define B_RSV_LO 20
`define B_SENSE 19
`define B_ACCEPT_LVL 18
`define B_ACK_MODE 17
`define B_ACK_POL 16
`define B_DSTEP_HI 15
`define B_DSTEP_LO 14
`define B_SSTEP_HI 13
`define B_SSTEP_LO 12
`define B_RSRC_HI 11
`define B_RSRC_LO 8
`define B_BURST 7
`define B_ENABLE 0
// writable mask; bits 23..20 always read zero
`define CTRL_WMASK 32'hff0ffff7
`define CTRL_HI_CH_MASK 32'hfffafff7
// stepping encodings
`define STEP_FIXED 2'h0
`define STEP_INC 2'h1
`define STEP_DEC 2'h2
// request-source encodings
`define RS_EXT_DUAL 4'h0
`define RS_EXT_MEM2DEV 4'h2
`define RS_EXT_DEV2MEM 4'h3
`define RS_AUTO_EE 4'h4
`define RS_AUTO_EP 4'h5
`define RS_AUTO_PE 4'h6
`define RS_SER_TX 4'h8
`define RS_SER_RX 4'h9
`define RS_FSER_TX 4'ha
`define RS_FSER_RX 4'hb
`define RS_TMR_EE 4'hc
`define RS_TMR_EP 4'hd
`define RS_TMR_PE 4'he
`endif

// [design/edge_sampler.v]
`timescale 1ns/1ps
// samples one request pin: low level or falling edge, one cycle registered
module edge_sampler (
	// clock and reset
	input wire clk,
	input wire arst_n,
	// control
	input wire edgeMode,
	input wire clearReq,
	// pin (active low request)
	input wire reqPin_n,
	// result
	output reg reqSeen_q
);
	reg prevPin_q;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prevPin_q <= 1'b1;
			reqSeen_q <= 1'b0;
		end else begin
			prevPin_q <= reqPin_n;
			if (!edgeMode)
				reqSeen_q <= ~reqPin_n;
			else if (prevPin_q && !reqPin_n)
				reqSeen_q <= 1'b1; // set wins over clear
			else if (clearReq)
				reqSeen_q <= 1'b0;
		end
	end
endmodule // edge_sampler

// [design/dma_channel_mode_control.v]
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "dma_mode_consts.vh"
// Summary of operation
// - destination wait bit picks area five or six
// - bits 23 to 20 read zero
// - request sense: low level or falling edge
// - sense bit: ch0-1 normal, all on-demand
// - burst mode: level or edge burst by sense
// - accept output polarity; ch0-1 normal only
// - ack in read or write cycle; single always
// - ack mode channel validity by mode, variant
// - ack output polarity; ch0-1 normal only
// - destination step fixed, increment, decrement
// - destination step ignored memory to device
// - channel 0 on-demand forces step increment
// - source step fixed, increment, decrement
// - source step ignored device to memory
// - external request transfer types decoded
// - auto-request transfer types decoded
// - serial event triggers decoded
// - timer capture triggers decoded
// - external requests only on channels 0-1 normal
// - bus mode: cycle steal or burst
module dma_channel_mode_control (
	// clock and reset
	input wire clk,
	input wire arst_n,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output wire wb_ack_o,
	output wire wb_err_o,
	// on-demand mode and variant strap
	input wire later_variant,
	// transfer request format received on channel 0 (pulse)
	input wire request_format_rx,
	// external request pins, active low, per channel
	input wire [3:0] transfer_request_pin_n,
	// on-chip event sources
	input wire serial_tx_empty,
	input wire serial_rx_full,
	input wire fifo_serial_tx_empty,
	input wire fifo_serial_rx_full,
	input wire timer_capture,
	// engine side: cycle phase for the active channel
	input wire [1:0] active_ch,
	input wire read_phase,
	input wire write_phase,
	input wire accept_now,
	input wire [2:0] xfer_size,
	// outputs
	output reg [3:0] request_accept_out,
	output reg [3:0] transfer_ack_out,
	output reg [3:0] ch_request,
	output reg use_area6_wait,
	output reg [7:0] dest_step,
	output reg [7:0] src_step,
	output reg [3:0] burst_edge,
	output reg [3:0] burst_level,
	output reg [3:0] to_peripheral,
	output reg [3:0] from_peripheral,
	output reg [3:0] single_addr
);
	reg [31:0] ctrl_q [0:3];
	reg on_demand_mode_q;
	reg ackPend_q;
	reg [31:0] rdData_d;
	reg hit;
	wire acc = wb_cyc_i & wb_stb_i;
	wire [3:0] reqSeen;
	wire [3:0] extSense;
	wire [3:0] extAllowed;
	wire [3:0] chEnable;
	integer k;

	always @* begin
		case (wb_adr_i)
		`OFS_CTRL0, `OFS_CTRL1, `OFS_CTRL2, `OFS_CTRL3, `OFS_MODE, `OFS_STATUS: hit = 1'b1;
		default: hit = 1'b0;
		endcase
	end
	// ack one cycle after the strobe, dropped the cycle after
	assign wb_ack_o = ackPend_q & acc & hit;
	assign wb_err_o = ackPend_q & acc & ~hit;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			ackPend_q <= 1'b0;
		else
			ackPend_q <= acc & ~ackPend_q;
	end

	// byte-lane merge; reserved bits masked so they stay zero
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] sel;
		input [31:0] mask;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (sel[b])
					merge[b*8 +: 8] = nw[b*8 +: 8];
			merge = merge & mask;
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gCh
			wire [31:0] wmask = (g < 2) ? `CTRL_WMASK : (`CTRL_WMASK & `CTRL_HI_CH_MASK);
			wire wrHit = wb_ack_o & wb_we_i && (wb_adr_i == (`OFS_CTRL0 + 8'h04 * g));
			always @(posedge clk or negedge arst_n) begin
				if (!arst_n)
					ctrl_q[g] <= `CTRL_RESET;
				else if (g == 0 && on_demand_mode_q && request_format_rx) begin
					// fixed settings; step fields forced to increment
					ctrl_q[g] <= (ctrl_q[g] & 32'h00ff00f8) | 32'h00005001;
					ctrl_q[g][`B_SENSE] <= ctrl_q[g][`B_SENSE];
					ctrl_q[g][18:16] <= 3'h0;
				end else if (wrHit)
					ctrl_q[g] <= merge(ctrl_q[g], wb_dat_i, wb_sel_i, wmask);
			end
			wire [31:0] c = ctrl_q[g];
			// sense bit only counts where valid; else level detect
			assign extSense[g] = c[`B_SENSE] & ((g < 2) | on_demand_mode_q);
			// external requests on ch2-3 only in on-demand mode
			assign extAllowed[g] = (g < 2) | on_demand_mode_q;
			assign chEnable[g] = c[`B_ENABLE];
			edge_sampler uSamp (
				.clk(clk),
				.arst_n(arst_n),
				.edgeMode(extSense[g]),
				.clearReq(accept_now && active_ch == g),
				.reqPin_n(transfer_request_pin_n[g]),
				.reqSeen_q(reqSeen[g])
			);
		end
	endgenerate

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			on_demand_mode_q <= 1'b0;
		else if (wb_ack_o && wb_we_i && wb_adr_i == `OFS_MODE && wb_sel_i[0])
			on_demand_mode_q <= wb_dat_i[0];
	end

	// register readback
	always @* begin
		case (wb_adr_i)
		`OFS_CTRL0: rdData_d = ctrl_q[0];
		`OFS_CTRL1: rdData_d = ctrl_q[1];
		`OFS_CTRL2: rdData_d = ctrl_q[2];
		`OFS_CTRL3: rdData_d = ctrl_q[3];
		`OFS_MODE: rdData_d = {31'h0, on_demand_mode_q};
		`OFS_STATUS: rdData_d = {28'h0, reqSeen};
		default: rdData_d = 32'h00000000;
		endcase
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			wb_dat_o <= 32'h00000000;
		else if (acc && !ackPend_q)
			wb_dat_o <= rdData_d;
	end

	// step amount in bytes for a size code
	function [7:0] stepBytes;
		input [2:0] sz;
		begin
			case (sz)
			3'h0: stepBytes = 8'h08;
			3'h1: stepBytes = 8'h01;
			3'h2: stepBytes = 8'h02;
			3'h3: stepBytes = 8'h04;
			3'h4: stepBytes = 8'h20;
			default: stepBytes = 8'h00;
			endcase
		end
	endfunction

	function [7:0] stepOf;
		input [1:0] mode;
		input [7:0] amt;
		begin
			case (mode)
			`STEP_INC: stepOf = amt;
			`STEP_DEC: stepOf = 8'h00 - amt;
			default: stepOf = 8'h00; // fixed; 11 undefined
			endcase
		end
	endfunction

	// combinational decode of the active channel and per-channel sources
	reg [31:0] a;
	reg [3:0] rs;
	reg ackValid;
	reg ackPolValid;
	reg asserted;
	always @* begin
		a = ctrl_q[active_ch];
		rs = a[`B_RSRC_HI:`B_RSRC_LO];
		use_area6_wait = a[`B_DEST_WAIT];
		dest_step = stepOf(a[`B_DSTEP_HI:`B_DSTEP_LO], stepBytes(xfer_size));
		src_step = stepOf(a[`B_SSTEP_HI:`B_SSTEP_LO], stepBytes(xfer_size));
		if (rs == `RS_EXT_MEM2DEV)
			dest_step = 8'h00;
		if (rs == `RS_EXT_DEV2MEM)
			src_step = 8'h00;
		for (k = 0; k < 4; k = k + 1) begin
			rs = ctrl_q[k][`B_RSRC_HI:`B_RSRC_LO];
			single_addr[k] = (rs == `RS_EXT_MEM2DEV) | (rs == `RS_EXT_DEV2MEM);
			to_peripheral[k] = (rs == `RS_AUTO_EP) | (rs == `RS_TMR_EP) | (rs == `RS_SER_TX)
				| (rs == `RS_FSER_TX);
			from_peripheral[k] = (rs == `RS_AUTO_PE) | (rs == `RS_TMR_PE) | (rs == `RS_SER_RX)
				| (rs == `RS_FSER_RX);
			case (rs)
			`RS_EXT_DUAL, `RS_EXT_MEM2DEV, `RS_EXT_DEV2MEM:
				ch_request[k] = extAllowed[k] & reqSeen[k];
			`RS_AUTO_EE, `RS_AUTO_EP, `RS_AUTO_PE:
				ch_request[k] = 1'b1;
			`RS_SER_TX: ch_request[k] = serial_tx_empty;
			`RS_SER_RX: ch_request[k] = serial_rx_full;
			`RS_FSER_TX: ch_request[k] = fifo_serial_tx_empty;
			`RS_FSER_RX: ch_request[k] = fifo_serial_rx_full;
			`RS_TMR_EE, `RS_TMR_EP, `RS_TMR_PE:
				ch_request[k] = timer_capture;
			default: ch_request[k] = 1'b0;
			endcase
			ch_request[k] = ch_request[k] & chEnable[k];
			burst_edge[k] = ctrl_q[k][`B_BURST] & extSense[k];
			burst_level[k] = ctrl_q[k][`B_BURST] & ~extSense[k];
			// polarity bits only honoured on ch0-1 in normal mode
			ackPolValid = (k < 2) & ~on_demand_mode_q;
			// ack cycle mode validity
			if (!on_demand_mode_q)
				ackValid = (k < 2);
			else
				ackValid = (k != 0) | later_variant;
			asserted = 1'b0;
			if (active_ch == k[1:0]) begin
				if (single_addr[k])
					asserted = read_phase | write_phase;
				else if (ackValid && ctrl_q[k][`B_ACK_MODE])
					asserted = write_phase;
				else
					asserted = read_phase;
			end
			transfer_ack_out[k] = asserted ^ (ackPolValid & ctrl_q[k][`B_ACK_POL]);
			request_accept_out[k] = (accept_now && active_ch == k[1:0])
				^ (ackPolValid & ctrl_q[k][`B_ACCEPT_LVL]);
		end
	end
endmodule // dma_channel_mode_control

// [testbench/dma_mode_asserts.sv]
`timescale 1ns/1ps
module dma_mode_asserts (
	// clock and reset
	input wire clk,
	input wire arst_n,
	// bus
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire wb_err_o,
	// decoded mode
	input wire [7:0] dest_step,
	input wire [7:0] src_step,
	input wire [3:0] burst_edge,
	input wire [3:0] burst_level,
	input wire [3:0] to_peripheral,
	input wire [3:0] from_peripheral
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// only sizes 1,2,4,8,32 exist, so any other step is a decode slip
	function automatic bit legal(input [7:0] s);
		return s inside {8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h20,
			8'hff, 8'hfe, 8'hfc, 8'hf8, 8'he0};
	endfunction
	a_bus_answer: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o || wb_err_o)
		else $error("bus request not answered");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_qualified: assert property (wb_ack_o || wb_err_o |-> wb_cyc_i && wb_stb_i)
		else $error("answer without request");
	a_rsv_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[23:20] == 4'h0)
		else $error("reserved bits not zero");
	a_upper_absent: assert property (wb_ack_o && !wb_we_i && wb_adr_i inside {8'h08, 8'h0c}
		|-> !wb_dat_o[18] && !wb_dat_o[16])
		else $error("absent level bits read one");
	a_burst_excl: assert property ((burst_edge & burst_level) == 4'h0)
		else $error("edge and level burst together");
	a_dstep_legal: assert property (legal(dest_step)) else $error("bad dest step");
	a_sstep_legal: assert property (legal(src_step)) else $error("bad src step");
	a_dir_excl: assert property ((to_peripheral & from_peripheral) == 4'h0)
		else $error("both peripheral directions");
endmodule // dma_mode_asserts
bind dma_channel_mode_control dma_mode_asserts dma_mode_asserts_i (.*);

// [testbench/req_device_model.sv]
`timescale 1ns/1ps
module req_device_model (
	// clock
	input wire clk,
	// request command per channel
	input wire [3:0] pulse,
	// request pins, pulled up when released
	output reg [3:0] reqPin_n_q
);
	reg [3:0] hold_q = 4'h0;
	initial reqPin_n_q = 4'hf;
	// a request holds the line low two cycles so level sampling sees it
	always @(posedge clk) begin
		hold_q <= pulse;
		reqPin_n_q <= ~(pulse | hold_q);
	end
endmodule // req_device_model

// [testbench/dma_channel_mode_control_test.sv]
`timescale 1ns/1ps
`include "dma_mode_consts.vh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("wrong value %0t got %h exp %h", $time, a, e); end end
module dma_channel_mode_control_test;
	reg clk = 0, arst_n = 0, cyc = 0, stb = 0, we = 0, lastErr;
	reg rdP = 0, wrP = 0, acc = 0, lv = 0, fmt = 0;
	reg [7:0] adr = 0;
	reg [31:0] wd = 0, q;
	reg [3:0] pulse = 0;
	reg [1:0] ch = 0;
	reg [2:0] sz = 0;
	reg [4:0] ev = 0;
	wire [31:0] rdat;
	wire ack, err, area6;
	wire [3:0] pinN, accOut, ackOut, req, bE, bL, toP, fromP, sgl;
	wire [7:0] dS, sS;
	int mismatches = 0, total_checks = 0, cycles = 0;
	dma_channel_mode_control dma_channel_mode_control_i (.clk(clk), .arst_n(arst_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
		.later_variant(lv), .request_format_rx(fmt), .transfer_request_pin_n(pinN),
		.serial_tx_empty(ev[0]), .serial_rx_full(ev[1]), .fifo_serial_tx_empty(ev[2]),
		.fifo_serial_rx_full(ev[3]), .timer_capture(ev[4]), .active_ch(ch),
		.read_phase(rdP), .write_phase(wrP), .accept_now(acc), .xfer_size(sz),
		.request_accept_out(accOut), .transfer_ack_out(ackOut), .ch_request(req),
		.use_area6_wait(area6), .dest_step(dS), .src_step(sS), .burst_edge(bE),
		.burst_level(bL), .to_peripheral(toP), .from_peripheral(fromP), .single_addr(sgl));
	req_device_model req_device_model_i (.clk(clk), .pulse(pulse), .reqPin_n_q(pinN));
	initial forever #20 clk = ~clk;
	always @(posedge clk) if (++cycles == 20000) begin
		mismatches++;
		close_out;
	end
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic bus(input w, input [7:0] a, input [31:0] d);
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wd <= d;
		// answer is sampled at the rising edge only; the cycle timeout ends a hang
		@(posedge clk);
		while (!(ack || err)) @(posedge clk);
		q = rdat;
		lastErr = err;
		cyc <= 0;
		stb <= 0;
		// let the write settle before callers look at decoded outputs
		@(negedge clk);
	endtask
	task wr(input [7:0] a, input [31:0] d); bus(1, a, d); endtask
	task rd(input [7:0] a, input [31:0] m, input [31:0] e); bus(0, a, 0); `CHK(q & m, e) endtask
	function [7:0] stepOf(input [1:0] m, input [2:0] s);
		reg [7:0] b;
		b = (s == 0) ? 8'h08 : (s == 4) ? 8'h20 : 8'h01 << (s - 1);
		return (m == 1) ? b : (m == 2) ? -b : 8'h00;
	endfunction
	task t_regs;
		for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'hffffffff, 32'h0);
		wr(`OFS_CTRL0, 32'hfff5a8c4);
		rd(`OFS_CTRL0, 32'hffffffff, 32'hff05a8c4);
		wr(`OFS_CTRL2, 32'h00ff0000);
		rd(`OFS_CTRL2, 32'hffffffff, 32'h000a0000);
		bus(0, 8'h40, 0);
		`CHK(lastErr, 1'b1)
		@(negedge clk);
		`CHK(area6, 1'b1)
		`CHK(accOut[1:0], 2'b01)
		`CHK(ackOut[1:0], 2'b01)
		@(posedge clk) ch <= 1;
		@(negedge clk);
		`CHK(area6, 1'b0)
	endtask
	task t_ack;
		wr(`OFS_CTRL1, 32'h00020001);
		@(posedge clk) rdP <= 1;
		@(negedge clk);
		`CHK(ackOut[1], 1'b0)
		@(posedge clk) {rdP, wrP} <= 2'b01;
		@(negedge clk);
		`CHK(ackOut[1], 1'b1)
		@(posedge clk) {wrP, ch} <= 3'b000;
	endtask
	task t_step;
		for (int m = 0; m < 3; m++) for (int s = 0; s < 5; s++) begin
			wr(`OFS_CTRL0, {16'h0, 2'(m), 2'(m), 12'h0});
			@(posedge clk) sz <= 3'(s);
			@(negedge clk);
			`CHK(dS, stepOf(2'(m), 3'(s)))
			`CHK(sS, stepOf(2'(m), 3'(s)))
		end
		wr(`OFS_CTRL0, 32'h00004200);
		`CHK(dS, 8'h00)
		wr(`OFS_CTRL0, 32'h00001300);
		`CHK(sS, 8'h00)
	endtask
	task t_rsrc;
		for (int i = 0; i < 15; i++) if (!(i inside {1, 7})) begin
			wr(`OFS_CTRL0, 32'h00000080 | (i << 8) | (i[0] << 19));
			`CHK(sgl[0], 1'(i inside {2, 3}))
			`CHK(toP[0], 1'(i inside {5, 8, 10, 13}))
			`CHK(fromP[0], 1'(i inside {6, 9, 11, 14}))
			`CHK(bE[0], i[0])
			`CHK(bL[0], !i[0])
		end
		@(posedge clk) ev <= 5'h10;
		wr(`OFS_CTRL0, 32'h00000c01);
		`CHK(req[0], 1'b1)
		wr(`OFS_CTRL0, 32'h00000801);
		`CHK(req[0], 1'b0)
		wr(`OFS_CTRL0, 32'h00000401);
		`CHK(req[0], 1'b1)
		@(posedge clk) ev <= 5'h00;
		wr(`OFS_CTRL0, 32'h00000000);
	endtask
	task pin(input [3:0] p, input int n, input e); // drive pins, wait; e low: check pulsed channels show no request; e high: req is compared with itself
		@(posedge clk) pulse <= p;
		repeat (n) @(negedge clk);
		`CHK(req & {4{e}} | req & ~pulse & ~{4{e}} | {4{1'b0}}, req)
	endtask
	task t_sense;
		wr(`OFS_CTRL0, 32'h00080001);
		@(posedge clk) pulse <= 4'h1;
		@(posedge clk) pulse <= 4'h0;
		repeat (4) @(negedge clk);
		`CHK(req[0], 1'b1)
		@(posedge clk) acc <= 1;
		@(posedge clk) acc <= 0;
		@(negedge clk);
		`CHK(req[0], 1'b0)
		wr(`OFS_CTRL2, 32'h00080001);
		@(posedge clk) pulse <= 4'h4;
		repeat (4) @(negedge clk);
		`CHK(req[2], 1'b0)
		@(posedge clk) pulse <= 4'h0;
		wr(`OFS_MODE, 32'h1);
		@(posedge clk) pulse <= 4'h4;
		@(posedge clk) pulse <= 4'h0;
		repeat (4) @(negedge clk);
		`CHK(req[2], 1'b1)
	endtask
	initial begin
		repeat (16) @(posedge clk);
		arst_n <= 1;
		t_regs;
		t_ack;
		t_step;
		t_rsrc;
		t_sense;
		@(posedge clk) {fmt, lv} <= 2'b11;
		@(posedge clk) fmt <= 0;
		rd(`OFS_CTRL0, 32'hff07f007, 32'h00005001);
		close_out;
	end
endmodule // dma_channel_mode_control_test
